// ==== verilog/ocm_pkg.sv ====
/*
  Package for the offset cancel and monitor stage: register map, field positions,
  reset values, timing constants, averaging phase encoding and stream carriers.
  Assumes a 200 MHz register clock and a 20-bit signed acceleration stream.
*/
`default_nettype none

package ocm_pkg;

  // ==========================================================================
  // widths and timing
  // ==========================================================================
  localparam int SAMPLE_W = 20;
  localparam int CORR_W = 16;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned DS_TIME_US = 256;
  localparam int unsigned DS_CYCLES = DS_TIME_US * CLK_MHZ;
  localparam int unsigned BLANK_TIME_MS = 2100;
  localparam int unsigned BLANK_CYCLES = BLANK_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned STREC_TIME_US = 1000;
  localparam int unsigned STREC_CYCLES = STREC_TIME_US * CLK_MHZ;
  localparam int unsigned PHASE_SAMPLES = 2048;
  localparam int unsigned RING_PARTS = 6;
  localparam int unsigned AVG_THR_LSB = 1;
  localparam int unsigned TRIM_FRAC = 14;

  // ==========================================================================
  // register offsets
  // ==========================================================================
  localparam logic [7:0] OFS_DEVICE_CONFIG = 8'h00;
  localparam logic [7:0] OFS_DEVICE_CONTROL = 8'h04;
  localparam logic [7:0] OFS_AXIS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_LIMIT_HIGH = 8'h0c;
  localparam logic [7:0] OFS_LIMIT_LOW = 8'h10;
  localparam logic [7:0] OFS_CORRECTION = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MASK = 8'h1c;
  localparam logic [7:0] OFS_STATE = 8'h20;

  // ==========================================================================
  // fields and reset values
  // ==========================================================================
  localparam int CFG_OC_N_BIT = 0;
  localparam int CFG_WATCH_BIT = 1;
  localparam int CTL_INIT_BIT = 0;
  localparam int CTL_OVR_BIT = 1;
  localparam int CTL_PHASE_LSB = 2;
  localparam int ST_OVERRANGE_BIT = 0;
  localparam int ST_UPDATE_BIT = 1;
  localparam int ST_W = 2;
  localparam logic [1:0] DEVICE_CONFIG_RST = 2'h1;
  localparam logic [3:0] LOWPASS_RST = 4'h0;
  localparam logic [15:0] LIMIT_HIGH_RST = 16'h0400;
  localparam logic [15:0] LIMIT_LOW_RST = 16'h0400;

  typedef enum logic [1:0] {
    OCM_PH_START1 = 2'b00,
    OCM_PH_START2 = 2'b01,
    OCM_PH_START3 = 2'b11,
    OCM_PH_NORMAL = 2'b10
  } ocm_phase_t;

  typedef struct packed {
    logic valid;
    logic [SAMPLE_W-1:0] data;
  } ocm_sample_t;

endpackage : ocm_pkg

`default_nettype wire

// ==== verilog/ocm_offset_cancel.sv ====
/*
  Offset cancellation and offset monitor stage with APB register access.
  Assumes the low-pass stream and the host read command run on pclk; the self
  test pin is asynchronous; trim values come from one-time memory as static levels.
*/
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - corrected data only when select bit is zero in config and read command
// - normal phase averages 24,576 samples taken every 256 us
// - average against thresholds steps the correction value applied to data
// - three start-up phases of 2048 samples averaging 48, 384, 3072
// - correction refreshes every 2.048, 16.38, 131.1, 1049 ms by phase
// - before init complete, host may force phase via select and enable
// - self test freezes cancellation, monitor and correction value
// - cancellation stays frozen for a recovery time after self test ends
// - monitor runs only when its enable bit is one
// - correction beyond high or low limit raises over-range error
// - monitor evaluated only at correction refresh moments
// - monitor inactive for 2.1 s after reset
// - one-time trim corrects gain and offset of the signal path
// - host picks one of twelve low-pass responses via four-bit field
module ocm_offset_cancel #(
  parameter int unsigned DS_CYC = ocm_pkg::DS_CYCLES,
  parameter int unsigned BLANK_CYC = ocm_pkg::BLANK_CYCLES,
  parameter int unsigned STREC_CYC = ocm_pkg::STREC_CYCLES
) (
  input wire logic pclk, // register and dsp clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire ocm_pkg::ocm_sample_t lpf_in, // filtered acceleration
  input wire logic read_cmd_oc_n, // select bit of host read command
  input wire logic selftest_pin, // self test active, async
  input wire logic [15:0] trim_gain, // gain trim, 2.14 unsigned
  input wire logic [15:0] trim_offset, // offset trim, signed lsb
  output logic [3:0] lowpass_select, // filter choice for lpf stage
  output ocm_pkg::ocm_sample_t acc_out, // result stream
  output logic offset_error, // over-range error level
  output logic irq // interrupt level
);

  localparam int SW = ocm_pkg::SAMPLE_W;
  localparam int CW = ocm_pkg::CORR_W;
  localparam int AW = 40;

  // ==========================================================================
  // register file
  // ==========================================================================
  logic [1:0] dev_cfg_reg;
  logic init_complete_flag_reg;
  logic phase_override_enable_reg;
  logic [1:0] startup_phase_select_reg;
  logic [3:0] lowpass_reg;
  logic [15:0] offset_limit_high_reg;
  logic [15:0] offset_limit_low_reg;
  logic [ocm_pkg::ST_W-1:0] status_reg;
  logic [ocm_pkg::ST_W-1:0] mask_reg;
  logic [31:0] rdata_reg;
  logic signed [CW-1:0] correction_value_reg;
  ocm_pkg::ocm_phase_t phase_reg;
  ocm_pkg::ocm_phase_t eff_phase;
  logic [ocm_pkg::ST_W-1:0] ev_set;
  logic wr_en;
  logic setup;
  logic mapped;

  assign wr_en = psel & penable & pwrite;
  assign setup = psel & ~penable;
  assign pready = 1'b1;
  assign mapped = (paddr == ocm_pkg::OFS_DEVICE_CONFIG) || (paddr == ocm_pkg::OFS_DEVICE_CONTROL)
    || (paddr == ocm_pkg::OFS_AXIS_CONFIG) || (paddr == ocm_pkg::OFS_LIMIT_HIGH)
    || (paddr == ocm_pkg::OFS_LIMIT_LOW) || (paddr == ocm_pkg::OFS_CORRECTION)
    || (paddr == ocm_pkg::OFS_STATUS) || (paddr == ocm_pkg::OFS_MASK) || (paddr == ocm_pkg::OFS_STATE);
  assign pslverr = psel & penable & ~mapped;
  assign prdata = rdata_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dev_cfg_reg <= ocm_pkg::DEVICE_CONFIG_RST;
      init_complete_flag_reg <= 1'b0;
      phase_override_enable_reg <= 1'b0;
      startup_phase_select_reg <= 2'h0;
      lowpass_reg <= ocm_pkg::LOWPASS_RST;
      offset_limit_high_reg <= ocm_pkg::LIMIT_HIGH_RST;
      offset_limit_low_reg <= ocm_pkg::LIMIT_LOW_RST;
      mask_reg <= '0;
    end
    else if (wr_en)
    begin
      case (paddr)
        ocm_pkg::OFS_DEVICE_CONFIG: dev_cfg_reg <= pwdata[1:0];
        ocm_pkg::OFS_DEVICE_CONTROL:
        begin
          // init complete is sticky: once set, the phase override is locked out
          if (pwdata[ocm_pkg::CTL_INIT_BIT])
            init_complete_flag_reg <= 1'b1;
          phase_override_enable_reg <= pwdata[ocm_pkg::CTL_OVR_BIT];
          startup_phase_select_reg <= pwdata[ocm_pkg::CTL_PHASE_LSB +: 2];
        end
        ocm_pkg::OFS_AXIS_CONFIG: lowpass_reg <= pwdata[3:0];
        ocm_pkg::OFS_LIMIT_HIGH: offset_limit_high_reg <= pwdata[15:0];
        ocm_pkg::OFS_LIMIT_LOW: offset_limit_low_reg <= pwdata[15:0];
        ocm_pkg::OFS_MASK: mask_reg <= pwdata[ocm_pkg::ST_W-1:0];
        default: ;
      endcase
    end
  end

  assign lowpass_select = lowpass_reg;

  // read data captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_reg <= '0;
    else if (setup && !pwrite)
    begin
      case (paddr)
        ocm_pkg::OFS_DEVICE_CONFIG: rdata_reg <= {30'h0, dev_cfg_reg};
        ocm_pkg::OFS_DEVICE_CONTROL: rdata_reg <= {28'h0, startup_phase_select_reg,
                                                   phase_override_enable_reg, init_complete_flag_reg};
        ocm_pkg::OFS_AXIS_CONFIG: rdata_reg <= {28'h0, lowpass_reg};
        ocm_pkg::OFS_LIMIT_HIGH: rdata_reg <= {16'h0, offset_limit_high_reg};
        ocm_pkg::OFS_LIMIT_LOW: rdata_reg <= {16'h0, offset_limit_low_reg};
        ocm_pkg::OFS_CORRECTION: rdata_reg <= {{16{correction_value_reg[CW-1]}}, correction_value_reg};
        ocm_pkg::OFS_STATUS: rdata_reg <= {30'h0, status_reg};
        ocm_pkg::OFS_MASK: rdata_reg <= {30'h0, mask_reg};
        ocm_pkg::OFS_STATE: rdata_reg <= {30'h0, eff_phase};
        default: rdata_reg <= 32'h0;
      endcase
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_reg <= '0;
    else if (wr_en && paddr == ocm_pkg::OFS_STATUS)
      status_reg <= (status_reg & ~pwdata[ocm_pkg::ST_W-1:0]) | ev_set;
    else
      status_reg <= status_reg | ev_set;
  end

  assign irq = |(status_reg & mask_reg);
  assign offset_error = status_reg[ocm_pkg::ST_OVERRANGE_BIT];

  // ==========================================================================
  // self test synchroniser, recovery and monitor blanking
  // ==========================================================================
  logic st_s1, st_s2, st_s3, st_level;
  logic [31:0] strec_cnt;
  logic [31:0] blank_cnt;
  logic frozen;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_s1 <= 1'b0;
      st_s2 <= 1'b0;
      st_s3 <= 1'b0;
      st_level <= 1'b0;
    end
    else
    begin
      st_s1 <= selftest_pin;
      st_s2 <= st_s1;
      st_s3 <= st_s2;
      if (st_s2 == st_s3)
        st_level <= st_s3;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      strec_cnt <= '0;
    else if (st_level)
      strec_cnt <= STREC_CYC;
    else if (strec_cnt != 0)
      strec_cnt <= strec_cnt - 32'h1;
  end

  assign frozen = st_level || (strec_cnt != 0);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      blank_cnt <= BLANK_CYC;
    else if (blank_cnt != 0)
      blank_cnt <= blank_cnt - 32'h1;
  end

  // ==========================================================================
  // trim and output path
  // ==========================================================================
  logic signed [SW+16:0] trim_prod;
  logic [SW-1:0] trimmed;
  logic [SW-1:0] last_sample;
  logic use_corr;

  assign trim_prod = $signed(lpf_in.data) * $signed({1'b0, trim_gain});
  assign trimmed = trim_prod[ocm_pkg::TRIM_FRAC +: SW] + {{(SW-16){trim_offset[15]}}, trim_offset};
  assign use_corr = ~dev_cfg_reg[ocm_pkg::CFG_OC_N_BIT] & ~read_cmd_oc_n;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_out <= '0;
      last_sample <= '0;
    end
    else
    begin
      acc_out.valid <= lpf_in.valid;
      if (lpf_in.valid)
      begin
        last_sample <= trimmed;
        if (use_corr)
          acc_out.data <= trimmed - {{(SW-CW){correction_value_reg[CW-1]}}, correction_value_reg};
        else
          acc_out.data <= trimmed;
      end
    end
  end

  // ==========================================================================
  // down-sampling, phases and running average
  // ==========================================================================
  logic [31:0] ds_cnt;
  logic ds_tick;
  logic [10:0] ph_cnt;
  ocm_pkg::ocm_phase_t eff_phase_d;
  logic [11:0] part_cnt;
  logic [11:0] part_last;
  logic [3:0] part_shift;
  logic signed [AW-1:0] part_acc;
  logic signed [AW-1:0] ring [ocm_pkg::RING_PARTS];
  logic [2:0] ring_wr;
  logic [2:0] ring_fill;
  logic upd;
  logic signed [AW-1:0] total;
  logic signed [AW-1:0] diff6;
  logic signed [CW-1:0] corr_new;

  always_comb
  begin
    if (!init_complete_flag_reg && phase_override_enable_reg)
    begin
      case (startup_phase_select_reg)
        2'h0: eff_phase = ocm_pkg::OCM_PH_START1;
        2'h1: eff_phase = ocm_pkg::OCM_PH_START2;
        2'h2: eff_phase = ocm_pkg::OCM_PH_START3;
        default: eff_phase = ocm_pkg::OCM_PH_NORMAL;
      endcase
    end
    else
      eff_phase = phase_reg;
  end

  // samples per ring part; six parts make 48, 384, 3072 or 24576
  always_comb
  begin
    case (eff_phase)
      ocm_pkg::OCM_PH_START1: part_shift = 4'h3;
      ocm_pkg::OCM_PH_START2: part_shift = 4'h6;
      ocm_pkg::OCM_PH_START3: part_shift = 4'h9;
      default: part_shift = 4'hc;
    endcase
    part_last = 12'((13'h1 << part_shift) - 13'h1);
  end

  assign ds_tick = (ds_cnt == DS_CYC - 1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ds_cnt <= '0;
    else if (ds_tick)
      ds_cnt <= '0;
    else
      ds_cnt <= ds_cnt + 32'h1;
  end

  // phase timer keeps running through self test; only averaging freezes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_reg <= ocm_pkg::OCM_PH_START1;
      ph_cnt <= '0;
    end
    else if (ds_tick && phase_reg != ocm_pkg::OCM_PH_NORMAL)
    begin
      ph_cnt <= ph_cnt + 11'h1;
      if (ph_cnt == 11'(ocm_pkg::PHASE_SAMPLES - 1))
      begin
        case (phase_reg)
          ocm_pkg::OCM_PH_START1: phase_reg <= ocm_pkg::OCM_PH_START2;
          ocm_pkg::OCM_PH_START2: phase_reg <= ocm_pkg::OCM_PH_START3;
          default: phase_reg <= ocm_pkg::OCM_PH_NORMAL;
        endcase
      end
    end
  end

  // a phase change restarts the ring, as parts of different size cannot mix
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eff_phase_d <= ocm_pkg::OCM_PH_START1;
      part_cnt <= '0;
      part_acc <= '0;
      ring_wr <= '0;
      ring_fill <= '0;
      upd <= 1'b0;
      for (int i = 0; i < ocm_pkg::RING_PARTS; i++)
        ring[i] <= '0;
    end
    else
    begin
      eff_phase_d <= eff_phase;
      upd <= 1'b0;
      if (eff_phase != eff_phase_d)
      begin
        part_cnt <= '0;
        part_acc <= '0;
        ring_wr <= '0;
        ring_fill <= '0;
      end
      else if (ds_tick && !frozen)
      begin
        if (part_cnt == part_last)
        begin
          ring[ring_wr] <= part_acc + AW'($signed(last_sample));
          part_acc <= '0;
          part_cnt <= '0;
          ring_wr <= (ring_wr == 3'(ocm_pkg::RING_PARTS - 1)) ? 3'h0 : ring_wr + 3'h1;
          if (ring_fill != 3'(ocm_pkg::RING_PARTS))
            ring_fill <= ring_fill + 3'h1;
          upd <= 1'b1;
        end
        else
        begin
          part_acc <= part_acc + AW'($signed(last_sample));
          part_cnt <= part_cnt + 12'h1;
        end
      end
    end
  end

  // ==========================================================================
  // correction step and offset monitor
  // ==========================================================================
  always_comb
  begin
    total = '0;
    for (int i = 0; i < ocm_pkg::RING_PARTS; i++)
      total = total + ring[i];
    // six times the average against six times the correction avoids a divider
    diff6 = (total >>> part_shift) - AW'(correction_value_reg * 6);
    corr_new = correction_value_reg;
    if (diff6 >= AW'(6 * ocm_pkg::AVG_THR_LSB))
      corr_new = correction_value_reg + 16'sh1;
    else if (diff6 <= -AW'(6 * ocm_pkg::AVG_THR_LSB))
      corr_new = correction_value_reg - 16'sh1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      correction_value_reg <= '0;
    else if (upd && !frozen && ring_fill == 3'(ocm_pkg::RING_PARTS))
      correction_value_reg <= corr_new;
  end

  always_comb
  begin
    ev_set = '0;
    if (upd && !frozen && ring_fill == 3'(ocm_pkg::RING_PARTS))
    begin
      ev_set[ocm_pkg::ST_UPDATE_BIT] = 1'b1;
      if (dev_cfg_reg[ocm_pkg::CFG_WATCH_BIT] && blank_cnt == 0
          && (corr_new > $signed(offset_limit_high_reg)
              || corr_new < -$signed(offset_limit_low_reg)))
        ev_set[ocm_pkg::ST_OVERRANGE_BIT] = 1'b1;
    end
  end

endmodule : ocm_offset_cancel

`default_nettype wire

// ==== dv/ocm_offset_cancel_assertions.sv ====
/*
  Checker for the offset stage: stream, monitor, filter select.
  Assumes pready high; bound onto the design top below.
*/
`timescale 1ns/1ps
`default_nettype none

module ocm_offset_cancel_assertions #(
  parameter int unsigned BLANK_CYC = 50
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic pready, // apb ready
  input wire ocm_pkg::ocm_sample_t lpf_in, // filtered input
  input wire logic read_cmd_oc_n, // read command select
  input wire logic selftest_pin, // self test
  input wire logic [15:0] trim_gain, // gain trim
  input wire logic [15:0] trim_offset, // offset trim
  input wire logic [3:0] lowpass_select, // filter choice
  input wire ocm_pkg::ocm_sample_t acc_out, // result stream
  input wire logic offset_error // over-range level
);
  // ==========================================================================
  // helper logic
  // ==========================================================================
  logic wr;
  logic clr0;
  logic watch_q;
  logic [31:0] blank_cnt;
  assign wr = psel && penable && pwrite && pready;
  assign clr0 = wr && paddr == ocm_pkg::OFS_STATUS && pwdata[0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      blank_cnt <= 32'h0;
    else if (blank_cnt < BLANK_CYC)
      blank_cnt <= blank_cnt + 32'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      watch_q <= 1'b0;
    else if (wr && paddr == ocm_pkg::OFS_DEVICE_CONFIG)
      watch_q <= pwdata[ocm_pkg::CFG_WATCH_BIT];
  end

  // ==========================================================================
  // properties
  // ==========================================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // the synchroniser needs a few cycles, so only a long hold is judged
  sequence s_st_held;
    selftest_pin [*8];
  endsequence
  sequence s_raw_sample;
    lpf_in.valid && read_cmd_oc_n && trim_gain == 16'h4000 && trim_offset == 16'h0000;
  endsequence

  property p_out_lat;
    lpf_in.valid |=> acc_out.valid;
  endproperty
  a_out_lat: assert property (p_out_lat) else $error("result valid missing after sample");
  property p_out_only;
    acc_out.valid |-> $past(lpf_in.valid);
  endproperty
  a_out_only: assert property (p_out_only) else $error("result valid without sample");
  property p_pass_raw;
    s_raw_sample |=> acc_out.data == $past(lpf_in.data);
  endproperty
  a_pass_raw: assert property (p_pass_raw) else $error("uncorrected result differs");
  property p_blank;
    blank_cnt < BLANK_CYC |-> !offset_error;
  endproperty
  a_blank: assert property (p_blank) else $error("monitor active during blanking");
  property p_sticky;
    offset_error && !clr0 |=> offset_error;
  endproperty
  a_sticky: assert property (p_sticky) else $error("over-range error dropped");
  property p_st_freeze;
    s_st_held |=> !$rose(offset_error);
  endproperty
  a_st_freeze: assert property (p_st_freeze) else $error("monitor ran in self test");
  property p_watch;
    $rose(offset_error) |-> $past(watch_q) || $past(watch_q, 2);
  endproperty
  a_watch: assert property (p_watch) else $error("error raised with monitor off");
  property p_lowpass;
    wr && paddr == ocm_pkg::OFS_AXIS_CONFIG |=> lowpass_select == $past(pwdata[3:0]);
  endproperty
  a_lowpass: assert property (p_lowpass) else $error("filter select not updated");
endmodule : ocm_offset_cancel_assertions

bind ocm_offset_cancel ocm_offset_cancel_assertions #(.BLANK_CYC(BLANK_CYC)) chk_u (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .lpf_in, .read_cmd_oc_n, .selftest_pin, .trim_gain, .trim_offset,
  .lowpass_select, .acc_out, .offset_error);

`default_nettype wire

// ==== dv/ocm_lpf_model.sv ====
/*
  Low-pass stage model: a settled DC level.
  Assumes the same clock; spacing follows the filter choice.
*/
`timescale 1ns/1ps
`default_nettype none

module ocm_lpf_model (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic run, // stream on
  input wire logic [19:0] level, // settled filter output
  input wire logic [3:0] lowpass_select, // filter choice from device
  output var ocm_pkg::ocm_sample_t lpf_out // sample stream
);
  logic [3:0] cnt;
  logic [3:0] gap;
  // responses 8 and up have twice the sample time
  assign gap = (lowpass_select >= 4'h8) ? 4'h5 : 4'h2;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 4'h0;
      lpf_out <= '0;
    end
    else
    begin
      cnt <= (cnt >= gap) ? 4'h0 : cnt + 4'h1;
      lpf_out.valid <= run && cnt >= gap;
      // data is scrambled between samples
      lpf_out.data <= (run && cnt >= gap) ? level : ~lpf_out.data;
    end
  end
endmodule : ocm_lpf_model

`default_nettype wire

// ==== dv/ocm_offset_cancel_tb.sv ====
/*
  Bench for the offset stage over APB and the sample stream.
  Assumes short timing parameters and a constant stream level.
*/
`timescale 1ns/1ps
`default_nettype none

module ocm_offset_cancel_tb;
  localparam int unsigned DS = 4;
  localparam int unsigned STREC = 10;
  localparam logic [19:0] LVL = 20'h00064;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, read_cmd_oc_n, selftest_pin;
  logic offset_error, irq, run, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, c0;
  logic [15:0] trim_gain, trim_offset;
  logic [3:0] lowpass_select;
  ocm_pkg::ocm_sample_t lpf_in, acc_out;
  int n_mismatch, compares, n;

  ocm_offset_cancel #(.DS_CYC(DS), .BLANK_CYC(50), .STREC_CYC(STREC)) dut_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .lpf_in, .read_cmd_oc_n, .selftest_pin, .trim_gain,
    .trim_offset, .lowpass_select, .acc_out, .offset_error, .irq);
  ocm_lpf_model model_u (.pclk, .presetn, .run, .level(LVL), .lowpass_select, .lpf_out(lpf_in));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic hang(input string name);
    n_mismatch++;
    $display("wrong value %s expected done seen timeout", name);
    report_and_stop();
  endtask : hang

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (k = 1; k < 20 && pready !== 1'b1; k++)
      @(posedge pclk);
    if (pready !== 1'b1)
      hang("apb ready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk($sformatf("register %h", a), exp, rd);
  endtask : rdchk

  task automatic clr(input logic [31:0] v);
    xfer(ocm_pkg::OFS_STATUS, 1'b1, v);
  endtask : clr

  // always steps one edge first so a clear still pending is not mistaken
  task automatic wait_irq(output int k);
    @(posedge pclk);
    for (k = 1; k < 20000 && irq !== 1'b1; k++)
      @(posedge pclk);
    if (irq !== 1'b1)
      hang("refresh interrupt");
  endtask : wait_irq

  task automatic wait_out(input logic [19:0] exp, input string name);
    int k;
    repeat (3) @(posedge pclk);
    for (k = 1; k < 20 && acc_out.valid !== 1'b1; k++)
      @(posedge pclk);
    if (acc_out.valid !== 1'b1)
      hang(name);
    chk(name, {12'h0, exp}, {12'h0, acc_out.data});
  endtask : wait_out

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial
  begin
    {presetn, psel, penable, pwrite, selftest_pin, run} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    read_cmd_oc_n = 1'b1;
    trim_gain = 16'h4000;
    trim_offset = 16'h0000;
    n_mismatch = 0;
    compares = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(ocm_pkg::OFS_DEVICE_CONFIG, 32'h1);
    rdchk(ocm_pkg::OFS_LIMIT_HIGH, 32'h400);
    rdchk(ocm_pkg::OFS_LIMIT_LOW, 32'h400);
    rdchk(ocm_pkg::OFS_MASK, 32'h0);
    rdchk(ocm_pkg::OFS_STATE, 32'h0);
    xfer(ocm_pkg::OFS_CORRECTION, 1'b1, 32'h5);
    rdchk(ocm_pkg::OFS_CORRECTION, 32'h0);
    xfer(8'h24, 1'b0, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    xfer(ocm_pkg::OFS_AXIS_CONFIG, 1'b1, 32'hb);
    rdchk(ocm_pkg::OFS_AXIS_CONFIG, 32'hb);
    chk("lowpass port", 32'hb, {28'h0, lowpass_select});
    $display("test registers done");
    run <= 1'b1;
    wait_out(LVL, "raw sample");
    trim_offset <= 16'h0005;
    wait_out(LVL + 20'h5, "offset trim");
    trim_offset <= 16'h0000;
    trim_gain <= 16'h8000;
    wait_out(LVL << 1, "gain trim");
    trim_gain <= 16'h4000;
    $display("test stream done");
    xfer(ocm_pkg::OFS_MASK, 1'b1, 32'h2);
    for (int p = 0; p < 4; p++)
    begin
      xfer(ocm_pkg::OFS_DEVICE_CONTROL, 1'b1, {28'h0, 2'(p), 2'b10});
      // phase codes run in gray order
      rdchk(ocm_pkg::OFS_STATE, {30'h0, 1'(p >> 1), 1'((p >> 1) ^ p)});
      if (p < 3)
      begin
        clr(32'h3);
        wait_irq(n);
        clr(32'h2);
        wait_irq(n);
        chk("refresh interval", 32'(DS << (3 + 3 * p)), 32'(n + 3));
      end
    end
    xfer(ocm_pkg::OFS_DEVICE_CONTROL, 1'b1, 32'h2);
    $display("test phases done");
    xfer(ocm_pkg::OFS_MASK, 1'b1, 32'h0);
    clr(32'h3);
    repeat (300) @(posedge pclk);
    chk("masked irq", 32'h0, {31'h0, irq});
    rdchk(ocm_pkg::OFS_STATUS, 32'h2);
    xfer(ocm_pkg::OFS_MASK, 1'b1, 32'h2);
    xfer(ocm_pkg::OFS_DEVICE_CONFIG, 1'b1, 32'h0);
    clr(32'h2);
    wait_irq(n);
    xfer(ocm_pkg::OFS_CORRECTION, 1'b0, 32'h0);
    c0 = rd;
    clr(32'h2);
    @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wait_irq(n);
    rdchk(ocm_pkg::OFS_CORRECTION, c0 + 32'h1);
    read_cmd_oc_n <= 1'b0;
    wait_out(LVL - rd[19:0], "corrected sample");
    read_cmd_oc_n <= 1'b1;
    wait_out(LVL, "command selects raw");
    $display("test correction done");
    xfer(ocm_pkg::OFS_LIMIT_HIGH, 1'b1, 32'h0);
    repeat (100) @(posedge pclk);
    chk("monitor off", 32'h0, {31'h0, offset_error});
    clr(32'h2);
    wait_irq(n);
    clr(32'h2);
    xfer(ocm_pkg::OFS_DEVICE_CONFIG, 1'b1, 32'h2);
    @(posedge pclk);
    chk("before refresh", 32'h0, {31'h0, offset_error});
    wait_irq(n);
    repeat (2) @(posedge pclk);
    chk("over range", 32'h1, {31'h0, offset_error});
    $display("test monitor done");
    xfer(ocm_pkg::OFS_DEVICE_CONFIG, 1'b1, 32'h0);
    xfer(ocm_pkg::OFS_LIMIT_HIGH, 1'b1, 32'h400);
    xfer(ocm_pkg::OFS_CORRECTION, 1'b0, 32'h0);
    c0 = rd;
    selftest_pin <= 1'b1;
    repeat (400) @(posedge pclk);
    rdchk(ocm_pkg::OFS_CORRECTION, c0);
    selftest_pin <= 1'b0;
    repeat (STREC) @(posedge pclk);
    rdchk(ocm_pkg::OFS_CORRECTION, c0);
    repeat (300) @(posedge pclk);
    xfer(ocm_pkg::OFS_CORRECTION, 1'b0, 32'h0);
    chk("correction resumes", 32'h1, {31'h0, rd !== c0});
    $display("test self test done");
    report_and_stop();
  end
endmodule : ocm_offset_cancel_tb

`default_nettype wire
